// ---- dpr_device.sv ----
// Precharge, refresh, self refresh and power-down tracking of an eight-bank DRAM.
`timescale 1ns/1ps
`include "dpr_defs.svh"

module dpr_device #(
	parameter int TW = 8,
	parameter int GW = 11
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite register slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Command and address pins from the memory controller.
	input wire dpr_pkg::dpr_pins_type pins,
	// Device state.
	output dpr_pkg::dpr_status_type status
);

	// Cycle counts derived from the times.
	localparam logic [TW-1:0] ROW_PRE_CYC = TW'(`DPR_CEIL_CYC(`DPR_ROW_PRECHARGE_PS));
	localparam logic [TW-1:0] ALL_PRE_CYC = TW'(`DPR_CEIL_CYC(`DPR_ALL_BANK_PRECHARGE_PS));
	localparam logic [TW-1:0] REF_CYCLE_CYC = TW'(`DPR_CEIL_CYC(`DPR_REFRESH_CYCLE_PS));
	localparam logic [TW-1:0] SR_NONREAD_CYC = TW'(`DPR_CEIL_CYC(`DPR_SR_EXIT_NONREAD_PS));
	localparam logic [TW-1:0] SR_READ_CYC = TW'(`DPR_SR_EXIT_READ_CYC);
	localparam logic [TW-1:0] PD_EXIT_CYC = TW'(`DPR_PD_EXIT_CYC);
	localparam logic [TW-1:0] FAST_READ_CYC = TW'(`DPR_FAST_EXIT_READ_CYC);
	localparam logic [TW-1:0] SLOW_READ_CYC = TW'(`DPR_SLOW_EXIT_READ_CYC);
	localparam logic [1:0] CKE_MIN = 2'(`DPR_CKE_MIN_PULSE_CYC);
	localparam logic [GW-1:0] GAP_LIM = GW'(`DPR_FLOOR_CYC(
		`DPR_REFRESH_GAP_INTERVALS * `DPR_REFRESH_INTERVAL_PS));
	localparam logic [GW-1:0] GAP_LIM_IT = GW'(`DPR_FLOOR_CYC(
		`DPR_REFRESH_GAP_INTERVALS * `DPR_REFRESH_INTERVAL_IT_PS));

	// The counters must hold the longest delay and the refresh gap.
	if ((2 ** TW) - 1 < `DPR_SR_EXIT_READ_CYC) begin : g_tw_chk
		$error("dpr_device: TW too small for the read exit delay");
	end
	if ((2 ** GW) - 1 < `DPR_FLOOR_CYC(`DPR_REFRESH_GAP_INTERVALS * `DPR_REFRESH_INTERVAL_PS))
	begin : g_gw_chk
		$error("dpr_device: GW too small for the refresh gap");
	end

	// Decodes the strobes into a command.
	function automatic dpr_pkg::dpr_cmd_type decode_cmd(input dpr_pkg::dpr_pins_type p);
		if (p.cs_n) begin
			return dpr_pkg::CMD_DESELECT;
		end
		case ({p.ras_n, p.cas_n, p.we_n})
			3'h3: return dpr_pkg::CMD_ACTIVATE;
			3'h5: return dpr_pkg::CMD_READ;
			3'h4: return dpr_pkg::CMD_WRITE;
			3'h2: return dpr_pkg::CMD_PRECHARGE;
			3'h1: return dpr_pkg::CMD_REFRESH;
			3'h0: return dpr_pkg::CMD_LOAD_MODE;
			default: return dpr_pkg::CMD_NOP;
		endcase
	endfunction

	// Pin synchroniser stages; the first is read only by the second.
	dpr_pkg::dpr_pins_type pins_s1;
	dpr_pkg::dpr_pins_type cur;
	// Clock enable seen at the previous edge and the run of equal levels.
	logic cke_prev;
	logic [1:0] cke_run;
	// Power state, bank state and loop state.
	dpr_pkg::dpr_state_type state;
	logic [7:0] bank_open;
	logic dll_enabled;
	logic slow_exit;
	// Software control and sticky flags.
	logic [1:0] ctrl;
	logic [2:0] flags;
	// Refresh gap counter.
	logic [GW-1:0] gap_cnt;
	// Bus data-phase bookkeeping.
	logic wr_pend;
	logic rd_pend;
	logic [7:0] dp_addr;

	// Decoded command and events of the current edge.
	dpr_pkg::dpr_cmd_type cmd;
	logic all_sel;
	logic nop_like;
	logic cmd_ok;
	logic cke_fall;
	logic cke_rise;
	logic sr_entry;
	logic pd_entry;
	logic pd_exit;
	logic sr_exit;
	logic auto_ref;
	logic nonread_cmd;
	// Timer strobes and results.
	logic [7:0] bank_load;
	logic [7:0] bank_busy;
	logic [TW-1:0] pre_val;
	logic [TW-1:0] nonread_val;
	logic [TW-1:0] read_val;
	logic refresh_busy;
	logic nonread_busy;
	logic read_busy;
	// Flag set terms and bus write strobes.
	logic [2:0] flag_set;
	logic addr_ok;

	// Two-stage synchroniser on all controller pins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pins_s1 <= '0;
			cur <= '0;
		end else begin
			pins_s1 <= pins;
			cur <= pins_s1;
		end
	end

	// Counts how many edges the clock enable level has been registered.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cke_prev <= 1'b0;
			cke_run <= 2'h0;
		end else begin
			cke_prev <= cur.cke;
			if (cur.cke != cke_prev) begin
				cke_run <= 2'h1;
			end else if (cke_run < CKE_MIN) begin
				cke_run <= cke_run + 2'h1;
			end
		end
	end

	// Command decode and event terms of the registered edge.
	always_comb begin
		cmd = decode_cmd(cur);
		all_sel = cur.addr[`DPR_PRECHARGE_ALL_BIT];
		nop_like = (cmd == dpr_pkg::CMD_NOP) || (cmd == dpr_pkg::CMD_DESELECT);
		cmd_ok = (state == dpr_pkg::ST_NORMAL) && cke_prev && cur.cke;
		// Level must have stood three registrations.
		cke_fall = cke_prev && !cur.cke && (cke_run >= CKE_MIN);
		cke_rise = !cke_prev && cur.cke && (cke_run >= CKE_MIN);
		// Self refresh only from all idle, termination off.
		sr_entry = (state == dpr_pkg::ST_NORMAL) && cke_fall &&
			(cmd == dpr_pkg::CMD_REFRESH) && (bank_open == 8'h00) &&
			!cur.termination_control;
		// Power-down entry only with NOP or deselect.
		pd_entry = (state == dpr_pkg::ST_NORMAL) && cke_fall && nop_like;
		// Power-down exit on a NOP or deselect with clock enable high.
		pd_exit = ((state == dpr_pkg::ST_PRECHARGE_PD) ||
			(state == dpr_pkg::ST_ACTIVE_PD)) && cke_rise && nop_like;
		// Self refresh exit at the first high registration.
		sr_exit = (state == dpr_pkg::ST_SELF_REFRESH) && cke_rise;
		auto_ref = cmd_ok && (cmd == dpr_pkg::CMD_REFRESH);
		nonread_cmd = cmd_ok && !nop_like && (cmd != dpr_pkg::CMD_READ);
	end

	// Power state machine.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= dpr_pkg::ST_NORMAL;
		end else begin
			case (state)
				dpr_pkg::ST_NORMAL: begin
					if (sr_entry) begin
						state <= dpr_pkg::ST_SELF_REFRESH;
					end else if (pd_entry) begin
						// Kind of power-down chosen by open rows.
						state <= (bank_open != 8'h00) ? dpr_pkg::ST_ACTIVE_PD :
							dpr_pkg::ST_PRECHARGE_PD;
					end
				end
				dpr_pkg::ST_PRECHARGE_PD, dpr_pkg::ST_ACTIVE_PD: begin
					if (pd_exit) begin
						state <= dpr_pkg::ST_NORMAL;
					end
				end
				dpr_pkg::ST_SELF_REFRESH: begin
					if (sr_exit) begin
						state <= dpr_pkg::ST_NORMAL;
					end
				end
				default: begin
					state <= dpr_pkg::ST_NORMAL;
				end
			endcase
		end
	end

	// Open or idle state of each bank.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bank_open <= 8'h00;
		end else if (cmd_ok) begin
			case (cmd)
				dpr_pkg::CMD_ACTIVATE: begin
					bank_open[cur.bank_select] <= 1'b1;
				end
				// Bit 10 high closes all banks, else the selected one.
				dpr_pkg::CMD_PRECHARGE: begin
					if (all_sel) begin
						bank_open <= 8'h00;
					end else begin
						bank_open[cur.bank_select] <= 1'b0;
					end
				end
				// Auto precharge closes the accessed bank at the command.
				dpr_pkg::CMD_READ, dpr_pkg::CMD_WRITE: begin
					if (all_sel) begin
						bank_open[cur.bank_select] <= 1'b0;
					end
				end
				// Refresh and mode commands leave bank state alone.
				default: begin
					bank_open <= bank_open;
				end
			endcase
		end
	end

	// Each precharged bank times its precharge period.
	always_comb begin
		pre_val = all_sel ? ALL_PRE_CYC : ROW_PRE_CYC;
		for (int i = 0; i < `DPR_BANKS; i++) begin
			// A later precharge restarts the period.
			bank_load[i] = cmd_ok && (cmd == dpr_pkg::CMD_PRECHARGE) &&
				(all_sel || (cur.bank_select == 3'(i)));
		end
	end

	// One precharge timer per bank.
	for (genvar g = 0; g < `DPR_BANKS; g++) begin : g_bank
		dpr_timer #(.W(TW)) u_pre (
			.hclk(hclk),
			.hresetn(hresetn),
			.load(bank_load[g]),
			.value(pre_val),
			.busy(bank_busy[g])
		);
	end

	// Refresh busy from the command for the cycle time.
	dpr_timer #(.W(TW)) u_refresh (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(auto_ref || sr_entry),
		.value(REF_CYCLE_CYC),
		.busy(refresh_busy)
	);

	// Exit delay values for the non-read and read timers.
	always_comb begin
		// Both exit delays start at the exit edge.
		nonread_val = sr_exit ? SR_NONREAD_CYC : PD_EXIT_CYC;
		if (sr_exit) begin
			// Loop relock before a read is served.
			read_val = SR_READ_CYC;
		end else if (state == dpr_pkg::ST_ACTIVE_PD) begin
			// Mode bit 12 picks slow or fast exit.
			read_val = slow_exit ? SLOW_READ_CYC : FAST_READ_CYC;
		end else begin
			read_val = PD_EXIT_CYC;
		end
	end

	// Non-read exit delay timer.
	dpr_timer #(.W(TW)) u_exit_nonread (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(sr_exit || pd_exit),
		.value(nonread_val),
		.busy(nonread_busy)
	);

	// Read exit delay timer.
	dpr_timer #(.W(TW)) u_exit_read (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(sr_exit || pd_exit),
		.value(read_val),
		.busy(read_busy)
	);

	// Loop switched off in self refresh and back on at exit.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dll_enabled <= 1'b1;
		end else if (sr_entry) begin
			dll_enabled <= 1'b0;
		end else if (sr_exit) begin
			dll_enabled <= 1'b1;
		end
	end

	// Slow-exit bit captured from a mode register load to bank 0.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slow_exit <= 1'b0;
		end else if (cmd_ok && (cmd == dpr_pkg::CMD_LOAD_MODE) && (cur.bank_select == 3'h0)) begin
			slow_exit <= cur.addr[`DPR_SLOW_EXIT_BIT];
		end
	end

	// Any refresh restarts the gap; self refresh keeps it at zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_cnt <= '0;
		end else if (auto_ref || (state == dpr_pkg::ST_SELF_REFRESH)) begin
			gap_cnt <= '0;
		end else if (gap_cnt != {GW{1'b1}}) begin
			gap_cnt <= gap_cnt + 1'b1;
		end
	end

	// Violation terms that set the sticky flags.
	always_comb begin
		// Gap limit depends on the temperature range bit.
		flag_set[`DPR_FLAG_GAP] = ctrl[`DPR_CTRL_GAP_EN] &&
			(gap_cnt >= (ctrl[`DPR_CTRL_INDUSTRIAL] ? GAP_LIM_IT : GAP_LIM));
		// Non-read command during the exit delay.
		flag_set[`DPR_FLAG_NONREAD] = nonread_cmd && nonread_busy;
		flag_set[`DPR_FLAG_READ] = cmd_ok && (cmd == dpr_pkg::CMD_READ) && read_busy;
	end

	// Address phase accepted on the bus.
	assign addr_ok = hsel && htrans[1] && hready;

	// Captures each accepted address phase for its data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok && hwrite;
			rd_pend <= addr_ok && !hwrite;
			if (addr_ok) begin
				dp_addr <= haddr[7:0];
			end
		end
	end

	// Control register written in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= 2'h0;
		end else if (wr_pend && (dp_addr == `DPR_OFS_CTRL)) begin
			ctrl <= hwdata[1:0];
		end
	end

	// Sticky flags: a write of one clears, a new event wins over the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= 3'h0;
		end else if (wr_pend && (dp_addr == `DPR_OFS_FLAGS)) begin
			flags <= (flags & ~hwdata[2:0]) | flag_set;
		end else begin
			flags <= flags | flag_set;
		end
	end

	// Read data loaded in the wait cycle, so a write just before is seen.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (rd_pend) begin
			case (dp_addr)
				`DPR_OFS_CTRL: hrdata <= {30'h0, ctrl};
				`DPR_OFS_STATUS: hrdata <= {7'h0, status.precharging, 1'b0, slow_exit,
					status.nonread_ready, status.read_ready, refresh_busy,
					status.dll_frozen, dll_enabled, state, bank_open};
				`DPR_OFS_FLAGS: hrdata <= {29'h0, flags};
				default: hrdata <= 32'h0;
			endcase
		end
	end

	// One wait state on reads, none on writes; always OKAY.
	assign hreadyout = !rd_pend;
	assign hresp = 1'b0;

	// Device state outputs.
	always_comb begin
		status.bank_open = bank_open;
		status.precharging = bank_busy;
		status.power_state = state;
		status.dll_enabled = dll_enabled;
		// Loop frozen in precharge power-down; buffers off when asleep.
		status.dll_frozen = (state == dpr_pkg::ST_PRECHARGE_PD);
		status.buffers_on = (state == dpr_pkg::ST_NORMAL);
		status.refresh_busy = refresh_busy;
		status.read_ready = (state == dpr_pkg::ST_NORMAL) && !read_busy && dll_enabled;
		status.nonread_ready = (state == dpr_pkg::ST_NORMAL) && !nonread_busy;
	end

	// Checks of the documented behaviour.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	all_bank_close_a: assert property (cmd_ok && cmd == dpr_pkg::CMD_PRECHARGE && all_sel
		|=> bank_open == 8'h00) else $error("all-bank precharge left a bank open");
	one_bank_close_a: assert property (cmd_ok && cmd == dpr_pkg::CMD_PRECHARGE && !all_sel
		|=> !bank_open[$past(cur.bank_select)]) else $error("bank not closed");
	precharge_timing_a: assert property (cmd_ok && cmd == dpr_pkg::CMD_PRECHARGE
		|=> status.precharging[$past(cur.bank_select)]) else $error("no precharge");
	sr_dll_off_a: assert property (state == dpr_pkg::ST_SELF_REFRESH |-> !dll_enabled)
		else $error("loop on in self refresh");
	sr_read_wait_a: assert property (sr_exit |=> (!status.read_ready && dll_enabled) [*8])
		else $error("read allowed too soon after self refresh");
	refresh_busy_a: assert property (auto_ref |=> refresh_busy [*3])
		else $error("refresh not busy");
	pd_classify_a: assert property (pd_entry && bank_open != 8'h00
		|=> state == dpr_pkg::ST_ACTIVE_PD) else $error("wrong power-down kind");
	pd_buffers_a: assert property (state == dpr_pkg::ST_PRECHARGE_PD
		|-> !status.buffers_on && status.dll_frozen) else $error("buffers on");
	cke_pulse_a: assert property ($changed(state) |-> $past(cke_run) >= CKE_MIN)
		else $error("state changed on a short clock enable pulse");
	sr_idle_a: assert property (state != dpr_pkg::ST_SELF_REFRESH ##1
		state == dpr_pkg::ST_SELF_REFRESH |-> $past(bank_open) == 8'h00)
		else $error("self refresh with open bank");
	ref_keeps_banks_a: assert property (auto_ref |=> $stable(bank_open))
		else $error("refresh changed banks");
	pd_exit_wait_a: assert property (pd_exit |=> !status.nonread_ready)
		else $error("no exit delay after power-down");

	sr_cycle_c: cover property (sr_entry ##[1:50] sr_exit);
	act_pd_c: cover property (pd_entry && bank_open != 8'h00 ##[1:50] pd_exit);
	repre_c: cover property (bank_load[0] ##1 bank_load[0]);
	gap_c: cover property (flag_set[`DPR_FLAG_GAP]);

endmodule

// ---- dpr_defs.svh ----
// Timing, offset and field constants of the precharge, refresh and power-down block.
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH

// Clock period of hclk in picoseconds (20 MHz).
`define DPR_CLK_PERIOD_PS 50000

// Least time rounded up, longest time rounded down, to whole hclk cycles.
`define DPR_CEIL_CYC(ps) (((ps) + `DPR_CLK_PERIOD_PS - 1) / `DPR_CLK_PERIOD_PS)
`define DPR_FLOOR_CYC(ps) ((ps) / `DPR_CLK_PERIOD_PS)

// Precharge, refresh and exit times in picoseconds.
`define DPR_ROW_PRECHARGE_PS 15000
`define DPR_ALL_BANK_PRECHARGE_PS 17500
`define DPR_REFRESH_CYCLE_PS 195000
`define DPR_SR_EXIT_NONREAD_PS 205000

// Exit delays and pulse widths already given in clock cycles.
`define DPR_SR_EXIT_READ_CYC 200
`define DPR_PD_EXIT_CYC 2
`define DPR_FAST_EXIT_READ_CYC 2
`define DPR_SLOW_EXIT_READ_CYC 7
`define DPR_CKE_MIN_PULSE_CYC 3

// Refresh interval in picoseconds and the number of intervals a gap may span.
`define DPR_REFRESH_INTERVAL_PS 7812500
`define DPR_REFRESH_INTERVAL_IT_PS 3900000
`define DPR_REFRESH_GAP_INTERVALS 9

// Address bus of the command pins and the fields within it.
`define DPR_ADDR_W 14
`define DPR_BANKS 8
`define DPR_PRECHARGE_ALL_BIT 10
`define DPR_SLOW_EXIT_BIT 12

// Register byte offsets on the AHB-Lite bus.
`define DPR_OFS_CTRL 8'h00
`define DPR_OFS_STATUS 8'h04
`define DPR_OFS_FLAGS 8'h08

// Control register fields.
`define DPR_CTRL_GAP_EN 0
`define DPR_CTRL_INDUSTRIAL 1

// Sticky flag register fields.
`define DPR_FLAG_GAP 0
`define DPR_FLAG_NONREAD 1
`define DPR_FLAG_READ 2

`endif

// ---- dpr_pkg.sv ----
// Types shared by the precharge, refresh and power-down block.
package dpr_pkg;

	// Commands decoded from the chip select and command strobes.
	typedef enum logic [2:0] {
		CMD_DESELECT,
		CMD_NOP,
		CMD_ACTIVATE,
		CMD_READ,
		CMD_WRITE,
		CMD_PRECHARGE,
		CMD_REFRESH,
		CMD_LOAD_MODE
	} dpr_cmd_type;

	// Power state of the device.
	typedef enum logic [1:0] {
		ST_NORMAL,
		ST_PRECHARGE_PD,
		ST_ACTIVE_PD,
		ST_SELF_REFRESH
	} dpr_state_type;

	// Command and address pins as driven by the memory controller.
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] bank_select;
		logic [13:0] addr;
		logic termination_control;
	} dpr_pins_type;

	// Device state as seen by the rest of the chip.
	typedef struct packed {
		logic [7:0] bank_open;
		logic [7:0] precharging;
		dpr_state_type power_state;
		logic dll_enabled;
		logic dll_frozen;
		logic buffers_on;
		logic refresh_busy;
		logic read_ready;
		logic nonread_ready;
	} dpr_status_type;

endpackage

// ---- dpr_timer.sv ----
// Loadable down-counter that reports busy until its delay has run out.
`timescale 1ns/1ps

module dpr_timer #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Load strobe and delay in cycles.
	input wire logic load,
	input wire logic [W-1:0] value,
	// High while the delay is still running.
	output logic busy
);

	// Remaining cycles of the delay.
	logic [W-1:0] count;

	// A width below one bit cannot count.
	if (W < 1) begin : g_chk
		$error("dpr_timer: W must be at least 1");
	end

	// A new load restarts the delay from its full value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= '0;
		end else if (load) begin
			count <= value;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	// Busy for exactly value cycles after the load edge.
	assign busy = (count != '0);

endmodule

// ---- dpr_ctrl_model.sv ----
// Memory controller model that drives the command and address pins of the device.
`timescale 1ns/1ps

module dpr_ctrl_model (
	// Clock shared with the device.
	input wire logic hclk,
	// Command and address pins toward the device.
	output dpr_pkg::dpr_pins_type pins
);
	// Power up with clock enable high, a NOP and termination off.
	initial begin
		pins = '0;
		pins.cke = 1'b1;
		{pins.ras_n, pins.cas_n, pins.we_n} = 3'b111;
	end

	// Drives one command for one edge, then NOP with the address lines inverted.
	// The idle count n after the NOP keeps each clock enable level for n + 2 edges.
	// Spacing and held levels.
	task automatic issue(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a,
		input logic cke, input logic term, input int n);
		@(posedge hclk);
		pins.cke <= cke;
		{pins.ras_n, pins.cas_n, pins.we_n} <= op;
		pins.bank_select <= ba;
		pins.addr <= a;
		pins.termination_control <= term;
		@(posedge hclk);
		{pins.ras_n, pins.cas_n, pins.we_n} <= 3'b111;
		pins.bank_select <= ~ba;
		pins.addr <= ~a;
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench of the precharge, refresh and power-down block.
`timescale 1ns/1ps

module testbench;
	// Bus master and pin signals.
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	dpr_pkg::dpr_pins_type pins;
	dpr_pkg::dpr_status_type status;
	int error_cnt = 0;
	int n_compared = 0;
	logic [31:0] rd;
	logic [31:0] banks;
	assign banks = {24'h0, status.bank_open};
	// Command codes on the row, column and write strobes.
	localparam logic [2:0] NOP = 3'h7, ACT = 3'h3, RD = 3'h5, PRE = 3'h2, REF = 3'h1, LMR = 3'h0;

	dpr_device dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.pins(pins), .status(status));
	dpr_ctrl_model ctl (.hclk(hclk), .pins(pins));

	// Clock of 50 ns.
	initial begin
		forever #25 hclk = ~hclk;
	end

	// Prints the counts and the verdict.
	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Compares one word.
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", w, e, g);
		end
	endtask

	// Waits for hready at a falling edge and takes read data there; bounded.
	task automatic wait_ready(output logic [31:0] d);
		int i;
		@(negedge hclk);
		for (i = 0; hreadyout !== 1'b1; i++) begin
			if (i == 20) begin
				error_cnt++;
				finish_test();
			end
			@(negedge hclk);
		end
		d = hrdata;
		@(posedge hclk);
	endtask

	// One single word transfer, write or read.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_ready(d);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(d);
		chk("hresp", 32'h0, {31'h0, hresp});
		@(negedge hclk);
	endtask

	// Waits for a power state, bounded, then compares it.
	task automatic wait_state(input dpr_pkg::dpr_state_type s);
		int i;
		for (i = 0; status.power_state !== s && i < 20; i++) @(negedge hclk);
		chk("power_state", {30'h0, s}, {30'h0, status.power_state});
		// A state that never came ends the run here.
		if (status.power_state !== s) begin
			finish_test();
		end
	endtask

	// Reset values, register access and an unmapped place.
	task automatic t_reset();
		chk("bank_open", 32'h0, banks);
		ahb(1'b0, 32'h04, 32'h0, rd);
		chk("status_reg", 32'h6400, rd);
		ahb(1'b1, 32'h0c, 32'hffff_ffff, rd);
		ahb(1'b0, 32'h0c, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		ahb(1'b1, 32'h00, 32'h3, rd);
		ahb(1'b0, 32'h00, 32'h0, rd);
		chk("ctrl", 32'h3, rd);
		ahb(1'b1, 32'h00, 32'h0, rd);
		$display("t_reset done");
	endtask

	// Single, repeated and all-bank precharge.
	task automatic t_precharge();
		ctl.issue(ACT, 3'h1, 14'h0123, 1'b1, 1'b0, 4);
		ctl.issue(ACT, 3'h5, 14'h0456, 1'b1, 1'b0, 4);
		chk("open_two", 32'h22, banks);
		ctl.issue(PRE, 3'h1, 14'h0000, 1'b1, 1'b0, 4);
		chk("pre_one", 32'h20, banks);
		ctl.issue(PRE, 3'h1, 14'h0000, 1'b1, 1'b0, 0);
		repeat (2) @(negedge hclk);
		chk("pre_busy", 32'h2, status.precharging);
		@(negedge hclk);
		chk("pre_done", 32'h0, status.precharging);
		chk("pre_idle", 32'h20, banks);
		ctl.issue(ACT, 3'h1, 14'h0123, 1'b1, 1'b0, 4);
		chk("reopen", 32'h22, banks);
		ctl.issue(PRE, 3'h0, 14'h0400, 1'b1, 1'b0, 4);
		chk("pre_all", 32'h0, banks);
		$display("t_precharge done");
	endtask

	// Refresh ignores the address and stays busy for its cycle time.
	task automatic t_refresh();
		int n;
		n = 0;
		ctl.issue(REF, 3'h7, 14'h3fff, 1'b1, 1'b0, 0);
		repeat (12) begin
			@(negedge hclk);
			n += (status.refresh_busy === 1'b1);
		end
		chk("refresh_cycles", 32'd4, n);
		chk("refresh_banks", 32'h0, banks);
		$display("t_refresh done");
	endtask

	// Active and precharge power-down entry and exit.
	task automatic t_powerdown();
		ctl.issue(ACT, 3'h2, 14'h0010, 1'b1, 1'b0, 4);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b0, 1'b0, 4);
		wait_state(dpr_pkg::ST_ACTIVE_PD);
		chk("apd_io", 32'h0, {status.buffers_on, status.dll_frozen});
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 4);
		wait_state(dpr_pkg::ST_NORMAL);
		ctl.issue(PRE, 3'h0, 14'h0400, 1'b1, 1'b0, 4);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b0, 1'b0, 4);
		wait_state(dpr_pkg::ST_PRECHARGE_PD);
		chk("ppd_io", 32'h1, {status.buffers_on, status.dll_frozen});
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 4);
		wait_state(dpr_pkg::ST_NORMAL);
		$display("t_powerdown done");
	endtask

	// A rise after two low edges is refused; a clean rise exits.
	task automatic t_short_cke();
		ctl.issue(NOP, 3'h0, 14'h0, 1'b0, 1'b0, 0);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 8);
		wait_state(dpr_pkg::ST_PRECHARGE_PD);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b0, 1'b0, 4);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 4);
		wait_state(dpr_pkg::ST_NORMAL);
		$display("t_short_cke done");
	endtask

	// Refused entries, then self refresh, exit delays and the read flag.
	task automatic t_self_refresh();
		ctl.issue(ACT, 3'h4, 14'h0020, 1'b1, 1'b0, 4);
		ctl.issue(REF, 3'h0, 14'h0, 1'b0, 1'b0, 4);
		wait_state(dpr_pkg::ST_NORMAL);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 4);
		ctl.issue(PRE, 3'h0, 14'h0400, 1'b1, 1'b1, 4);
		ctl.issue(REF, 3'h0, 14'h0, 1'b0, 1'b1, 4);
		wait_state(dpr_pkg::ST_NORMAL);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 4);
		ctl.issue(REF, 3'h0, 14'h0, 1'b0, 1'b0, 4);
		wait_state(dpr_pkg::ST_SELF_REFRESH);
		chk("sr_dll", 32'h0, status.dll_enabled);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 0);
		wait_state(dpr_pkg::ST_NORMAL);
		chk("exit_ready", 32'h4, {status.dll_enabled, status.read_ready, status.nonread_ready});
		ctl.issue(RD, 3'h0, 14'h0, 1'b1, 1'b0, 4);
		ahb(1'b0, 32'h08, 32'h0, rd);
		chk("flag_read", 32'h4, rd);
		ahb(1'b1, 32'h08, 32'h4, rd);
		ahb(1'b0, 32'h08, 32'h0, rd);
		chk("flag_clear", 32'h0, rd);
		repeat (150) @(negedge hclk);
		chk("read_wait", 32'h0, status.read_ready);
		repeat (60) @(negedge hclk);
		chk("read_done", 32'h1, status.read_ready);
		$display("t_self_refresh done");
	endtask

	// Exit speed bit from the main mode register, slow read exit, gap flag.
	task automatic t_mode();
		ctl.issue(LMR, 3'h0, 14'h1000, 1'b1, 1'b0, 4);
		ahb(1'b0, 32'h04, 32'h0, rd);
		chk("slow_exit", 32'h1, rd[15]);
		ctl.issue(LMR, 3'h1, 14'h0000, 1'b1, 1'b0, 4);
		ahb(1'b0, 32'h04, 32'h0, rd);
		chk("ext_mode", 32'h1, rd[15]);
		ctl.issue(ACT, 3'h3, 14'h0030, 1'b1, 1'b0, 4);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b0, 1'b0, 4);
		wait_state(dpr_pkg::ST_ACTIVE_PD);
		ctl.issue(NOP, 3'h0, 14'h0, 1'b1, 1'b0, 0);
		repeat (4) @(negedge hclk);
		chk("slow_exit_a", 32'h1, {status.read_ready, status.nonread_ready});
		repeat (4) @(negedge hclk);
		chk("slow_exit_b", 32'h1, {status.read_ready, status.nonread_ready});
		@(negedge hclk);
		chk("slow_exit_c", 32'h3, {status.read_ready, status.nonread_ready});
		ahb(1'b1, 32'h00, 32'h3, rd);
		repeat (800) @(negedge hclk);
		ahb(1'b0, 32'h08, 32'h0, rd);
		chk("flag_gap", 32'h1, rd);
		$display("t_mode done");
	endtask

	// Reset for six cycles, then every scenario in turn.
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
		t_reset();
		t_precharge();
		t_refresh();
		t_powerdown();
		t_short_cke();
		t_self_refresh();
		t_mode();
		finish_test();
	end
endmodule
